//--- shared/arf_pkg.sv
// arf_pkg: offsets, field positions, reset values and carrier types
// for the converter reference-selection register bank.
// assumes an 8-bit special-function register bus on the system clock.
package arf_pkg;

  localparam logic [7:0] ARF_OFS_TRIM_LOW  = 8'hbd;
  localparam logic [7:0] ARF_OFS_TRIM_HIGH = 8'hbe;
  localparam logic [7:0] ARF_OFS_REF_CTRL  = 8'hd1;

  localparam int ARF_POS_GND_SEL  = 5;
  localparam int ARF_POS_SRC_HI   = 4;
  localparam int ARF_POS_SRC_LO   = 3;
  localparam int ARF_POS_SENS_EN  = 2;
  localparam int ARF_POS_OFS_LOW  = 6;

  localparam logic [7:0] ARF_RST_REF_CTRL = 8'h18;
  localparam logic [7:0] ARF_RST_RDATA    = 8'h00;
  localparam logic [9:0] ARF_RST_TRIM     = 10'h000;

  // reference source encodings
  typedef enum logic [1:0] {
    ARF_SRC_EXT_PIN = 2'b00,
    ARF_SRC_SUPPLY  = 2'b01,
    ARF_SRC_DIG_1V8 = 2'b10,
    ARF_SRC_HS_REF  = 2'b11
  } arf_src_e;

  // converter phase status from the converter
  typedef struct packed {
    logic busy;      // converter needs its reference
    logic tracking;  // tracking/sampling phase
    logic convert;   // conversion phase
    logic temp_sel;  // temperature sensor is the sampled input
  } arf_conv_s;

  // steering outputs toward the analog section
  typedef struct packed {
    arf_src_e src_sel;    // reference mux select
    logic     hs_ref_en;  // high-speed reference enable
    logic     agnd_sel;   // 1: ground from analog ground pin
    logic     sens_en;    // temperature sensor enable
  } arf_ana_s;

endpackage : arf_pkg

//--- rtl/arf_trim_rom.sv
// arf_trim_rom: holds the factory offset value and presents it registered.
// assumes trim value is a stable input from fuse/flash after reset.
module arf_trim_rom
  import arf_pkg::*;
(
  input  wire logic       mclk,      // system clock
  input  wire logic       rstn,      // async reset, active low
  input  wire logic [9:0] trim_in,   // stored offset measurement
  output logic      [9:0] trim_q     // registered offset
);

  // captured by clock, never by the reset itself
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trim_q <= ARF_RST_TRIM;
    end else begin
      trim_q <= trim_in;
    end
  end

endmodule // arf_trim_rom

//--- rtl/arf_regs.sv
// arf_regs: reference control and temperature offset register bank.
// assumes single-cycle sfr reads/writes, address and data valid with strobe.

// Functional notes
// - the 10-bit factory offset reads as bits 9:2 in the high byte and bits 1:0 in low bits 7:6.
// - low offset bits 5:0 read zero and writes to them are ignored.
// - control bits 4:3 pick the reference: external pin, supply, 1.8 V digital, 1.65 V fast.
// - with the fast reference chosen it is enabled only while the converter is busy.
// - control bit 5 picks ground: 0 the ground pin, 1 the analog ground pin.
// - the analog ground pin, when chosen, is used in both tracking and conversion.
// - sampling the temperature sensor always uses internal chip ground.
// - with the fast reference chosen, conversion always uses internal chip ground.
// - control bit 2 turns the temperature sensor on when 1 and off when 0.
// - with the sensor disabled its output is left floating, readings meaningless.
// - control bits 7:6 and 1:0 read zero and ignore writes.
module arf_regs
  import arf_pkg::*;
(
  input  wire logic       mclk,        // system clock
  input  wire logic       rstn,        // async reset, active low
  input  wire logic [7:0] sfr_addr,    // register address
  input  wire logic       sfr_wr,      // write strobe
  input  wire logic       sfr_rd,      // read strobe
  input  wire logic [7:0] sfr_wdata,   // write data
  output logic      [7:0] sfr_rdata,   // registered read data
  input  wire logic [9:0] trim_value,  // factory offset value
  input  arf_conv_s       conv_stat,   // converter phase status
  output arf_ana_s        ana_ctrl     // registered analog steering
);

  // reset image of the stored fields, cut from the control reset value
  localparam logic [1:0] SRC_RST  = ARF_RST_REF_CTRL[ARF_POS_SRC_HI:ARF_POS_SRC_LO];
  localparam logic       GND_RST  = ARF_RST_REF_CTRL[ARF_POS_GND_SEL];
  localparam logic       SENS_RST = ARF_RST_REF_CTRL[ARF_POS_SENS_EN];

  // fast reference starts gated off: the converter is idle out of reset
  localparam arf_ana_s   ANA_RST  = '{src_sel:   arf_src_e'(SRC_RST),
                                      hs_ref_en: 1'b0,
                                      agnd_sel:  GND_RST,
                                      sens_en:   SENS_RST};

  // stored control fields and their next values
  logic [1:0] src_r;
  logic [1:0] src_nxt;
  logic       gnd_r;
  logic       gnd_nxt;
  logic       sens_r;
  logic       sens_nxt;

  // registered factory offset
  logic [9:0] trim_q;

  // address decode
  logic       hit_ctrl;
  logic       hit_low;
  logic       hit_high;
  logic       wr_ctrl;

  // read views and the selected byte
  logic [7:0] low_view;
  logic [7:0] high_view;
  logic [7:0] ctrl_view;
  logic [7:0] rdata_nxt;

  // ground and reference steering terms
  logic       hs_sel;
  logic       sense_sample;
  logic       hs_convert;
  logic       force_int_gnd;
  logic       pin_gnd_nxt;
  logic       hs_ref_nxt;
  arf_ana_s   ana_nxt;

  arf_trim_rom arf_trim_rom_inst (
    .mclk    (mclk),
    .rstn    (rstn),
    .trim_in (trim_value),
    .trim_q  (trim_q)
  );

  assign hit_ctrl = (sfr_addr == ARF_OFS_REF_CTRL);
  assign hit_low  = (sfr_addr == ARF_OFS_TRIM_LOW);
  assign hit_high = (sfr_addr == ARF_OFS_TRIM_HIGH);

  // offset registers have no write path at all
  assign wr_ctrl  = sfr_wr & hit_ctrl;

  // unwritable control bits are simply never stored
  assign src_nxt  = wr_ctrl ? sfr_wdata[ARF_POS_SRC_HI:ARF_POS_SRC_LO] : src_r;
  assign gnd_nxt  = wr_ctrl ? sfr_wdata[ARF_POS_GND_SEL] : gnd_r;
  assign sens_nxt = wr_ctrl ? sfr_wdata[ARF_POS_SENS_EN] : sens_r;

  assign low_view  = {trim_q[1:0], 6'h00};
  assign high_view = trim_q[9:2];
  assign ctrl_view = {2'b00, gnd_r, src_r, sens_r, 2'b00};

  // decodes are one-hot, so an or of the gated views selects; unmapped reads zero
  assign rdata_nxt = ({8{hit_ctrl}} & ctrl_view) |
                     ({8{hit_low}}  & low_view)  |
                     ({8{hit_high}} & high_view);

  assign hs_sel        = (src_r == ARF_SRC_HS_REF);
  assign sense_sample  = conv_stat.temp_sel & conv_stat.tracking;
  assign hs_convert    = hs_sel & conv_stat.convert;

  // chip-ground overrides win; otherwise the pin ground holds in both phases
  assign force_int_gnd = sense_sample | hs_convert;
  assign pin_gnd_nxt   = gnd_r & ~force_int_gnd;

  // fast reference follows converter demand, no software action needed
  assign hs_ref_nxt    = hs_sel & conv_stat.busy;

  assign ana_nxt.src_sel   = arf_src_e'(src_r);
  assign ana_nxt.hs_ref_en = hs_ref_nxt;
  assign ana_nxt.agnd_sel  = pin_gnd_nxt;
  assign ana_nxt.sens_en   = sens_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_r <= SRC_RST;
    end else begin
      src_r <= src_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gnd_r <= GND_RST;
    end else begin
      gnd_r <= gnd_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sens_r <= SENS_RST;
    end else begin
      sens_r <= sens_nxt;
    end
  end

  // outputs come from flops, one cycle behind the stored fields
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ana_ctrl <= ANA_RST;
    end else begin
      ana_ctrl <= ana_nxt;
    end
  end

  // read data holds between reads
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= ARF_RST_RDATA;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_nxt;
    end
  end

endmodule // arf_regs

//--- verif/arf_regs_checker.sv
// arf_regs_checker: port-level properties of the reference register bank.
// assumes it is bound to arf_regs and sees only that module's ports.
module arf_regs_checker
  import arf_pkg::*;
(
  input wire logic       mclk,       // system clock
  input wire logic       rstn,       // async reset, active low
  input wire logic [7:0] sfr_addr,   // register address
  input wire logic       sfr_wr,     // write strobe
  input wire logic       sfr_rd,     // read strobe
  input wire logic [7:0] sfr_wdata,  // write data
  input wire logic [7:0] sfr_rdata,  // read data
  input wire logic [9:0] trim_value, // factory offset
  input wire arf_conv_s  conv_stat,  // converter status
  input wire arf_ana_s   ana_ctrl    // analog steering
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire       wc = sfr_wr && sfr_addr == ARF_OFS_REF_CTRL;
  wire       hs = ana_ctrl.src_sel == ARF_SRC_HS_REF;
  wire       ts = conv_stat.temp_sel && conv_stat.tracking;
  wire [2:0] wf = sfr_wdata[4:2];
  property p_rd_hi; sfr_rd && sfr_addr == ARF_OFS_TRIM_HIGH |=> sfr_rdata == trim_value[9:2];
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("offset high byte wrong");
  property p_rd_lo; sfr_rd && sfr_addr == ARF_OFS_TRIM_LOW |=> sfr_rdata == {trim_value[1:0], 6'h00};
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("offset low byte wrong");
  property p_rd_ctl; sfr_rd && sfr_addr == ARF_OFS_REF_CTRL |=> {sfr_rdata[7:6], sfr_rdata[1:0]} == 4'h0;
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control unused bits not zero");
  property p_wr; wc |=> ##1 {ana_ctrl.src_sel, ana_ctrl.sens_en} == $past(wf, 2); endproperty
  a_wr: assert property (p_wr) else $error("control write not applied");
  property p_hs; $past(rstn) |-> ana_ctrl.hs_ref_en == (hs && $past(conv_stat.busy)); endproperty
  a_hs: assert property (p_hs) else $error("fast reference gating wrong");
  property p_tsamp; $past(ts) |-> !ana_ctrl.agnd_sel; endproperty
  a_tsamp: assert property (p_tsamp) else $error("sensor sampling not on chip ground");
  property p_hsconv; $past(conv_stat.convert) && hs |-> !ana_ctrl.agnd_sel; endproperty
  a_hsconv: assert property (p_hsconv) else $error("fast ref conversion not on chip ground");
  property p_gnd; wc && sfr_wdata[5] && sfr_wdata[4:3] != 2'b11 ##1 !ts |=> ana_ctrl.agnd_sel;
  endproperty
  a_gnd: assert property (p_gnd) else $error("analog ground pin not selected");
  c_hs: cover property (ana_ctrl.hs_ref_en);
  c_gnd: cover property (ana_ctrl.agnd_sel && $past(conv_stat.convert));
  c_ovr: cover property ($past(ts) && $past(ana_ctrl.agnd_sel));
endmodule // arf_regs_checker
bind arf_regs arf_regs_checker arf_regs_checker_inst (.mclk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .trim_value, .conv_stat, .ana_ctrl);

//--- verif/arf_regs_tb.sv
// arf_regs_tb: random and corner tests of the reference register bank.
// assumes arf_regs is the top of the bank, inputs driven at falling edge.
module arf_regs_tb
  import arf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rstn, sfr_wr, sfr_rd;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, ctl;
  logic [9:0]  trim_value;
  logic [31:0] s = 32'h00000053;
  arf_conv_s   conv_stat;
  arf_ana_s    ana_ctrl;
  int          errors = 0, n_checks = 0;
  arf_regs arf_regs_inst (.mclk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .trim_value, .conv_stat, .ana_ctrl);
  function logic [31:0] nx();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  function logic [4:0] ex(input logic [7:0] c, input arf_conv_s v);
    logic h;
    h = c[4:3] == 2'b11;
    return {c[4:3], h & v.busy, c[5] & ~((v.temp_sel & v.tracking) | (h & v.convert)), c[2]};
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // strobes stay up until the next call so back-to-back transfers need no gap
  task wr(input logic [7:0] a, input logic [7:0] d);
    {sfr_wr, sfr_rd} = 2'b10; sfr_addr = a; sfr_wdata = d;
    @(negedge mclk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    {sfr_wr, sfr_rd} = 2'b01; sfr_addr = a;
    @(negedge mclk);
    chk(sfr_rdata, e);
  endtask
  task close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    conv_stat = '0;
    trim_value = 10'(nx());
    repeat (2) @(negedge mclk);
    rstn = 1;
    @(negedge mclk);
    rd(ARF_OFS_REF_CTRL, ARF_RST_REF_CTRL);
    wr(ARF_OFS_TRIM_LOW, 8'hff);
    wr(ARF_OFS_TRIM_HIGH, 8'h00);
    rd(ARF_OFS_TRIM_LOW, {trim_value[1:0], 6'h00});
    rd(ARF_OFS_TRIM_HIGH, trim_value[9:2]);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 32; i++) begin
      ctl = 8'(nx());
      ctl[4:3] = i[1:0];
      conv_stat = arf_conv_s'(4'(nx()));
      wr(ARF_OFS_REF_CTRL, ctl);
      sfr_wr = 1'b0;
      ctl &= 8'h3c;
      @(negedge mclk);
      chk({3'h0, ana_ctrl}, {3'h0, ex(ctl, conv_stat)});
      rd(ARF_OFS_REF_CTRL, ctl);
    end
    // mid-run reset: steering and control return to their reset image
    rstn = 0;
    @(negedge mclk);
    chk({3'h0, ana_ctrl}, {3'h0, ex(ARF_RST_REF_CTRL, '0)});
    rstn = 1;
    @(negedge mclk);
    rd(ARF_OFS_REF_CTRL, ARF_RST_REF_CTRL);
    rd(ARF_OFS_TRIM_HIGH, trim_value[9:2]);
    close_out();
  end
endmodule // arf_regs_tb
